// File: dcm_params.svh
// timing counts, field positions, mode codes and readout pattern of the calibration-mode block
`ifndef DCM_PARAMS_SVH
`define DCM_PARAMS_SVH
`define DCM_MR1_WRLVL_BIT     7
`define DCM_MR3_READOUT_BIT   2
`define DCM_MR3_LOC_LSB       0
`define DCM_LOC_PATTERN       2'h0
`define DCM_PATTERN_BITS      8'hAA
`define DCM_BANK_MR0          3'h0
`define DCM_BANK_MR1          3'h1
`define DCM_BANK_MR3          3'h3
`define DCM_OTF_MODE          2'h1
`define DCM_FIXED_CHOP        2'h2
`define DCM_LEVEL_DELAY_NS    9
`define DCM_CLK_PERIOD_NS     100
`define DCM_LEVEL_DELAY_CYC   (((`DCM_LEVEL_DELAY_NS) + (`DCM_CLK_PERIOD_NS) - 1) / (`DCM_CLK_PERIOD_NS))
`define DCM_READ_LAT_DEF      6
`endif

// File: dcm_pkg.sv
// types of the calibration-mode block
package dcm_pkg;
    typedef enum logic [3:0] {
        DCM_CMD_NOP   = 4'h0,
        DCM_CMD_MRS   = 4'h1,
        DCM_CMD_READ  = 4'h2,
        DCM_CMD_READA = 4'h3,
        DCM_CMD_WRITE = 4'h4,
        DCM_CMD_OTHER = 4'h5
    } dcm_cmd_t;
    typedef enum logic [1:0] {
        DCM_ST_IDLE  = 2'b00,
        DCM_ST_WAIT  = 2'b01,
        DCM_ST_BURST = 2'b10
    } dcm_state_t;
endpackage

// File: dcm_level_sampler.sv
// write-leveling clock sampler on the strobe clock
`timescale 1ns/1ps
`include "dcm_params.svh"
module dcm_level_sampler (
    input  wire logic STROBE_I,
    input  wire logic STROBE_RESETN_I,
    input  wire logic CK_LEVEL_I,
    output logic      SAMPLE_TOGGLE_O,
    output logic      SAMPLE_VALUE_O
);
    logic sample_reg;
    logic sample_next;
    logic toggle_reg;
    logic toggle_next;

    // =====================================================
    // capture on rising strobe
    always_comb begin
        sample_next = CK_LEVEL_I;
        toggle_next = ~toggle_reg;
    end

    // strobe may stand still; value is taken over by the main clock domain
    always_ff @(posedge STROBE_I) begin
        if (!STROBE_RESETN_I) begin
            sample_reg <= 1'b0;
            toggle_reg <= 1'b0;
        end else begin
            sample_reg <= sample_next;
            toggle_reg <= toggle_next;
        end
    end

    assign SAMPLE_TOGGLE_O = toggle_reg;
    assign SAMPLE_VALUE_O  = sample_reg;
endmodule

// File: dcm_calib_modes.sv
// calibration modes: write-leveling feedback and calibration readout register
`timescale 1ns/1ps
`include "dcm_params.svh"
// Operation
// - leveling feedback on prime bit or all
// - enabled reads redirected, location selects
// - autoprecharge read acts as plain read
// - reset honoured in readout mode
// - disabled mode serves array always
// - bit zero carries data, others copy/zero
// - ignore bank, precharge, upper column bits
// - chop order follows column bit two
// - on-the-fly chop from chop bit
// - normal read latency applies
// - location zero gives alternating pattern
// - beat zero is pattern lsb
// - mode one bit seven toggles leveling
// - sampled clock shown after leveling delay
module dcm_calib_modes #(
    parameter int READ_LAT  = `DCM_READ_LAT_DEF,
    parameter bit ALL_BITS  = 1'b0,
    parameter bit COPY_BITS = 1'b1
) (
    input  wire logic              CLOCK_I,
    input  wire logic              RESETN_I,
    input  wire logic              STROBE_I,
    input  wire logic              STROBE_RESETN_I,
    input  wire logic              CK_LEVEL_I,
    input  wire dcm_pkg::dcm_cmd_t CMD_I,
    input  wire logic [2:0]        BANK_I,
    input  wire logic [14:0]       ADDR_I,
    input  wire logic [15:0]       ARRAY_DATA_I,
    output logic                   WRLVL_ACTIVE_O,
    output logic                   READOUT_ACTIVE_O,
    output logic                   ARRAY_READ_O,
    output logic                   ARRAY_WRITE_O,
    output logic                   PRECHARGE_O,
    output logic [15:0]            DQ_O,
    output logic                   DQ_OE_O,
    output logic                   BEAT_VALID_O
);
    logic       tog_s1_reg;
    logic       tog_s2_reg;
    logic       tog_s3_reg;
    logic       val_s1_reg;
    logic       val_s2_reg;
    logic       strobe_toggle;
    logic       strobe_value;

    logic       wrlvl_reg;
    logic       wrlvl_next;
    logic       readout_reg;
    logic       readout_next;

    logic [1:0] loc_reg;
    logic [1:0] loc_next;
    logic [1:0] bl_mode_reg;
    logic [1:0] bl_mode_next;

    logic       fb_reg;
    logic       fb_next;

    logic [7:0] lat_cnt_reg;
    logic [7:0] lat_cnt_next;
    logic [2:0] beat_reg;
    logic [2:0] beat_next;
    logic [2:0] last_reg;
    logic [2:0] last_next;

    logic [15:0] dq_reg;
    logic [15:0] dq_next;
    logic       oe_reg;
    logic       oe_next;
    logic       valid_reg;
    logic       valid_next;

    logic       arr_rd;
    logic       arr_wr;
    logic       prech;
    logic       is_read;
    logic       chop;
    logic       data_bit;
    dcm_pkg::dcm_state_t state_reg;
    dcm_pkg::dcm_state_t state_next;

    // two byte lanes, each with its own copy of the readout bit
    localparam int LANES = 2;

    // =====================================================
    // strobe domain
    dcm_level_sampler u_sampler (
        .STROBE_I        (STROBE_I),
        .STROBE_RESETN_I (STROBE_RESETN_I),
        .CK_LEVEL_I      (CK_LEVEL_I),
        .SAMPLE_TOGGLE_O (strobe_toggle),
        .SAMPLE_VALUE_O  (strobe_value)
    );

    // =====================================================
    // crossing: value is stable long before its toggle is seen
    always_ff @(posedge CLOCK_I) begin
        if (!RESETN_I) begin
            tog_s1_reg <= 1'b0;
            tog_s2_reg <= 1'b0;
            tog_s3_reg <= 1'b0;
            val_s1_reg <= 1'b0;
            val_s2_reg <= 1'b0;
        end else begin
            tog_s1_reg <= strobe_toggle;
            tog_s2_reg <= tog_s1_reg;
            tog_s3_reg <= tog_s2_reg;
            val_s1_reg <= strobe_value;
            val_s2_reg <= val_s1_reg;
        end
    end

    // read and read with autoprecharge share one decode
    function automatic logic read_cmd(input dcm_pkg::dcm_cmd_t c);
        read_cmd = (c == dcm_pkg::DCM_CMD_READ) || (c == dcm_pkg::DCM_CMD_READA);
    endfunction

    // pattern bit for a beat; reserved slots give zero
    function automatic logic pattern_bit(input logic [1:0] loc, input logic [2:0] beat);
        logic [7:0] pat;
        pat = `DCM_PATTERN_BITS;
        if (loc == `DCM_LOC_PATTERN) begin
            pattern_bit = pat[beat];
        end else begin
            pattern_bit = 1'b0;
        end
    endfunction

    // =====================================================
    // mode registers and command handling
    always_comb begin
        wrlvl_next   = wrlvl_reg;
        readout_next = readout_reg;
        loc_next     = loc_reg;
        bl_mode_next = bl_mode_reg;
        fb_next      = fb_reg;
        arr_rd       = 1'b0;
        arr_wr       = 1'b0;
        prech        = 1'b0;
        is_read      = read_cmd(CMD_I);

        if (CMD_I == dcm_pkg::DCM_CMD_MRS) begin
            if (BANK_I == `DCM_BANK_MR1) begin
                wrlvl_next = ADDR_I[`DCM_MR1_WRLVL_BIT];
            end else if (BANK_I == `DCM_BANK_MR3) begin
                readout_next = ADDR_I[`DCM_MR3_READOUT_BIT];
                loc_next     = ADDR_I[`DCM_MR3_LOC_LSB +: 2];
            end else if (BANK_I == `DCM_BANK_MR0) begin
                bl_mode_next = ADDR_I[1:0];
            end
        end

        if (!readout_reg) begin
            arr_rd = is_read;
            arr_wr = (CMD_I == dcm_pkg::DCM_CMD_WRITE);
            prech  = (CMD_I == dcm_pkg::DCM_CMD_READA);
        end

        // autoprecharge suppressed while readout mode holds
        if (wrlvl_reg && (tog_s3_reg != tog_s2_reg)) begin
            fb_next = val_s2_reg;
        end
    end

    // =====================================================
    // readout burst sequencer
    always_comb begin
        state_next   = state_reg;
        lat_cnt_next = lat_cnt_reg;
        beat_next    = beat_reg;
        last_next    = last_reg;
        valid_next   = 1'b0;
        chop         = (bl_mode_reg == `DCM_FIXED_CHOP) ||
                       ((bl_mode_reg == `DCM_OTF_MODE) && !ADDR_I[12]);
        data_bit     = 1'b0;

        case (state_reg)
            dcm_pkg::DCM_ST_IDLE: begin
                if (readout_reg && is_read) begin
                    // bank, column bits above two and precharge bit ignored
                    lat_cnt_next = 8'(READ_LAT);
                    beat_next    = (chop && ADDR_I[2]) ? 3'h4 : 3'h0;
                    last_next    = chop ? (ADDR_I[2] ? 3'h7 : 3'h3) : 3'h7;
                    state_next   = dcm_pkg::DCM_ST_WAIT;
                end
            end
            dcm_pkg::DCM_ST_WAIT: begin
                if (lat_cnt_reg <= 8'h01) begin
                    state_next = dcm_pkg::DCM_ST_BURST;
                end else begin
                    lat_cnt_next = lat_cnt_reg - 8'h01;
                end
            end
            dcm_pkg::DCM_ST_BURST: begin
                valid_next = 1'b1;
                beat_next  = beat_reg + 3'h1;
                if (beat_reg == last_reg) begin
                    state_next = dcm_pkg::DCM_ST_IDLE;
                end
            end
            default: begin
                state_next = dcm_pkg::DCM_ST_IDLE;
            end
        endcase
        data_bit = pattern_bit(loc_reg, beat_reg);
    end

    // =====================================================
    // data pins
    always_comb begin
        dq_next = 16'h0000;
        oe_next = 1'b0;
        if (state_reg == dcm_pkg::DCM_ST_BURST) begin
            oe_next = 1'b1;
            for (int lane = 0; lane < LANES; lane++) begin
                dq_next[lane*8]       = data_bit;
                dq_next[lane*8+1 +: 7] = COPY_BITS ? {7{data_bit}} : 7'h00;
            end
        end else if (wrlvl_reg) begin
            oe_next = 1'b1;
            if (ALL_BITS) begin
                dq_next = {16{fb_reg}};
            end else begin
                dq_next = {7'h00, fb_reg, 7'h00, fb_reg};
            end
        end
    end

    // =====================================================
    // state registers
    // synchronous reset clears readout mode in any state
    always_ff @(posedge CLOCK_I) begin
        if (!RESETN_I) begin
            wrlvl_reg   <= 1'b0;
            readout_reg <= 1'b0;
            loc_reg     <= 2'h0;
            bl_mode_reg <= 2'h0;
            fb_reg      <= 1'b0;
            state_reg   <= dcm_pkg::DCM_ST_IDLE;
            lat_cnt_reg <= 8'h00;
            beat_reg    <= 3'h0;
            last_reg    <= 3'h0;
            dq_reg      <= 16'h0000;
            oe_reg      <= 1'b0;
            valid_reg   <= 1'b0;
        end else begin
            wrlvl_reg   <= wrlvl_next;
            readout_reg <= readout_next;
            loc_reg     <= loc_next;
            bl_mode_reg <= bl_mode_next;
            fb_reg      <= fb_next;
            state_reg   <= state_next;
            lat_cnt_reg <= lat_cnt_next;
            beat_reg    <= beat_next;
            last_reg    <= last_next;
            dq_reg      <= dq_next;
            oe_reg      <= oe_next;
            valid_reg   <= valid_next;
        end
    end

    // =====================================================
    // outputs
    assign WRLVL_ACTIVE_O   = wrlvl_reg;
    assign READOUT_ACTIVE_O = readout_reg;
    assign ARRAY_READ_O     = arr_rd;
    assign ARRAY_WRITE_O    = arr_wr;
    assign PRECHARGE_O      = prech;
    assign DQ_O             = dq_reg;
    assign DQ_OE_O          = oe_reg;
    assign BEAT_VALID_O     = valid_reg;
endmodule

// File: dcm_calib_chk.sv
// checker: port assertions of the calibration-mode block
`timescale 1ns/1ps
module dcm_calib_chk #(parameter int READ_LAT = 6) (
    input wire logic              CLOCK_I,
    input wire logic              RESETN_I,
    input wire dcm_pkg::dcm_cmd_t CMD_I,
    input wire logic [2:0]        BANK_I,
    input wire logic [14:0]       ADDR_I,
    input wire logic              WRLVL_ACTIVE_O,
    input wire logic              READOUT_ACTIVE_O,
    input wire logic              ARRAY_READ_O,
    input wire logic              ARRAY_WRITE_O,
    input wire logic              PRECHARGE_O,
    input wire logic [15:0]       DQ_O,
    input wire logic              DQ_OE_O,
    input wire logic              BEAT_VALID_O
);
    logic ro_rd;
    logic mrs;
    assign ro_rd = READOUT_ACTIVE_O && CMD_I inside {dcm_pkg::DCM_CMD_READ, dcm_pkg::DCM_CMD_READA};
    assign mrs = CMD_I == dcm_pkg::DCM_CMD_MRS;
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (!RESETN_I);
    // ==========
    // assertions
    array_read_a: assert property (
        CMD_I == dcm_pkg::DCM_CMD_READ && !READOUT_ACTIVE_O |-> ARRAY_READ_O)
        else $error("array read missing");
    redirect_a: assert property (
        READOUT_ACTIVE_O |-> !(ARRAY_READ_O || ARRAY_WRITE_O || PRECHARGE_O))
        else $error("array touched in readout mode");
    ro_enable_a: assert property (
        mrs && BANK_I == 3'h3 |=> READOUT_ACTIVE_O == $past(ADDR_I[2]))
        else $error("readout enable wrong");
    lvl_mode_a: assert property (
        mrs && BANK_I == 3'h1 |=> WRLVL_ACTIVE_O == $past(ADDR_I[7]))
        else $error("leveling mode wrong");
    rst_clear_a: assert property (disable iff (1'b0)
        !RESETN_I |=> !READOUT_ACTIVE_O && !WRLVL_ACTIVE_O && !BEAT_VALID_O)
        else $error("reset not honoured");
    read_lat_a: assert property (
        $rose(BEAT_VALID_O) |-> $past(ro_rd, READ_LAT + 2))
        else $error("burst at wrong latency");
    burst_len_a: assert property (
        $rose(BEAT_VALID_O) |-> BEAT_VALID_O[*4] ##1
        (!BEAT_VALID_O || BEAT_VALID_O[*4] ##1 !BEAT_VALID_O))
        else $error("burst length wrong");
    lane_copy_a: assert property (
        BEAT_VALID_O |-> DQ_OE_O && DQ_O == {16{DQ_O[0]}})
        else $error("lane bits differ");
    first_beat_a: assert property (
        $rose(BEAT_VALID_O) |-> DQ_O == 16'h0000)
        else $error("first beat not zero");
    lvl_prime_a: assert property (
        WRLVL_ACTIVE_O |-> (DQ_O & 16'hFEFE) == 16'h0000)
        else $error("non-prime bits driven");
endmodule
bind dcm_calib_modes dcm_calib_chk #(.READ_LAT(READ_LAT)) dcm_calib_chk_i (
    .CLOCK_I(CLOCK_I), .RESETN_I(RESETN_I), .CMD_I(CMD_I), .BANK_I(BANK_I),
    .ADDR_I(ADDR_I), .WRLVL_ACTIVE_O(WRLVL_ACTIVE_O),
    .READOUT_ACTIVE_O(READOUT_ACTIVE_O), .ARRAY_READ_O(ARRAY_READ_O),
    .ARRAY_WRITE_O(ARRAY_WRITE_O), .PRECHARGE_O(PRECHARGE_O), .DQ_O(DQ_O),
    .DQ_OE_O(DQ_OE_O), .BEAT_VALID_O(BEAT_VALID_O));

// File: dcm_ctrl_model.sv
// controller model: commands, leveling strobe and clock level
`timescale 1ns/1ps
module dcm_ctrl_model (
    input  wire logic        CLOCK_I,
    output dcm_pkg::dcm_cmd_t CMD_O,
    output logic [2:0]       BANK_O,
    output logic [14:0]      ADDR_O,
    output logic             STROBE_O,
    output logic             STROBE_RESETN_O,
    output logic             CK_LEVEL_O
);
    // short stand-ins for the mode delays
    localparam int MRD = 4;
    localparam int MOD = 12;
    initial begin
        CMD_O = dcm_pkg::DCM_CMD_NOP;
        BANK_O = 3'h0;
        ADDR_O = 15'h0000;
        STROBE_O = 1'b0;
        CK_LEVEL_O = 1'b0;
        STROBE_RESETN_O = 1'b0;
        frame(1'b0, 2);
        STROBE_RESETN_O = 1'b1;
    end
    // no termination pin here: termination held off throughout
    // loop taken as locked; readout mode sees reads, one write and mode writes
    // nop inverts the address: a stale bus must not look valid
    task automatic put(input dcm_pkg::dcm_cmd_t c, input logic [2:0] b, input logic [14:0] a);
        @(negedge CLOCK_I);
        CMD_O = c;
        BANK_O = (c == dcm_pkg::DCM_CMD_NOP) ? ~BANK_O : b;
        ADDR_O = (c == dcm_pkg::DCM_CMD_NOP) ? ~ADDR_O : a;
    endtask
    // banks idle, recovery and mode delays kept around each write
    task automatic mrs(input logic [2:0] b, input logic [14:0] a);
        repeat (MRD) @(negedge CLOCK_I);
        put(dcm_pkg::DCM_CMD_MRS, b, a);
        put(dcm_pkg::DCM_CMD_NOP, b, a);
        repeat (MOD) @(negedge CLOCK_I);
    endtask
    // strobe runs only inside a frame, full widths, stops low after last fall
    task automatic frame(input logic lvl, input int n);
        CK_LEVEL_O = lvl;
        repeat (n) begin
            #24 STROBE_O = 1'b1;
            #24 STROBE_O = 1'b0;
        end
    endtask
endmodule

// File: testbench.sv
// self-checking bench of the calibration-mode block
`timescale 1ns/1ps
module testbench;
    localparam int RL = 5;
    typedef struct {logic [1:0] md; logic [1:0] loc; dcm_pkg::dcm_cmd_t c;
        logic [14:0] a; int n; logic [7:0] p;} dcm_row_t;
    // location sweep, burst modes, chop nibbles; junk in ignored bits
    dcm_row_t rows [8] = '{
        '{2'h0, 2'h0, dcm_pkg::DCM_CMD_READ, 15'h0000, 8, 8'hAA},
        '{2'h1, 2'h0, dcm_pkg::DCM_CMD_READA, 15'h1400, 8, 8'hAA},
        '{2'h1, 2'h0, dcm_pkg::DCM_CMD_READ, 15'h0000, 4, 8'h0A},
        '{2'h1, 2'h0, dcm_pkg::DCM_CMD_READA, 15'h0004, 4, 8'h0A},
        '{2'h2, 2'h0, dcm_pkg::DCM_CMD_READ, 15'h6BFC, 4, 8'h0A},
        '{2'h0, 2'h1, dcm_pkg::DCM_CMD_READ, 15'h0000, 8, 8'h00},
        '{2'h0, 2'h2, dcm_pkg::DCM_CMD_READ, 15'h0000, 8, 8'h00},
        '{2'h0, 2'h3, dcm_pkg::DCM_CMD_READ, 15'h0000, 8, 8'h00}};
    logic clock = 1'b0;
    logic resetn = 1'b0;
    dcm_pkg::dcm_cmd_t cmd;
    logic [2:0] bank;
    logic [14:0] addr;
    logic strobe, strobe_resetn, ck_level, wrlvl, ro, ard, awr, pre, oe, bv;
    logic [15:0] dq;
    int errors = 0;
    int checks = 0;
    always #50 clock = ~clock;
    dcm_ctrl_model m (.CLOCK_I(clock), .CMD_O(cmd), .BANK_O(bank), .ADDR_O(addr),
        .STROBE_O(strobe), .STROBE_RESETN_O(strobe_resetn), .CK_LEVEL_O(ck_level));
    dcm_calib_modes #(.READ_LAT(RL)) dcm_calib_modes_i (.CLOCK_I(clock),
        .RESETN_I(resetn), .STROBE_I(strobe), .STROBE_RESETN_I(strobe_resetn),
        .CK_LEVEL_I(ck_level), .CMD_I(cmd), .BANK_I(bank), .ADDR_I(addr),
        .ARRAY_DATA_I(16'h0000), .WRLVL_ACTIVE_O(wrlvl), .READOUT_ACTIVE_O(ro),
        .ARRAY_READ_O(ard), .ARRAY_WRITE_O(awr), .PRECHARGE_O(pre), .DQ_O(dq),
        .DQ_OE_O(oe), .BEAT_VALID_O(bv));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // one command, outputs looked at inside its own cycle
    task automatic cmd1(input dcm_pkg::dcm_cmd_t c, input logic [14:0] a);
        m.put(c, 3'h0, a);
        #10;
    endtask
    task automatic rdo(input dcm_row_t r);
        int k;
        k = 0;
        m.put(r.c, 3'h5, r.a);
        m.put(dcm_pkg::DCM_CMD_NOP, 3'h0, 15'h0000);
        while (bv !== 1'b1 && k < 20) begin
            @(negedge clock);
            k++;
        end
        check(16'(k), 16'(RL + 1));
        for (int i = 0; i < r.n; i++) begin
            check(dq, {16{r.p[i]}});
            @(negedge clock);
        end
        check(16'(bv), 16'h0000);
    endtask
    // about six times the expected run: a hang ends the run
    initial begin
        #400000;
        errors++;
        give_verdict();
    end
    initial begin
        repeat (20) @(negedge clock);
        resetn = 1'b1;
        foreach (rows[i]) begin
            m.mrs(3'h0, {13'h0000, rows[i].md});
            m.mrs(3'h3, {12'h000, 1'b1, rows[i].loc});
            rdo(rows[i]);
            m.mrs(3'h3, 15'h0000);
        end
        m.mrs(3'h3, 15'h0004);
        cmd1(dcm_pkg::DCM_CMD_WRITE, 15'h0000);
        check(16'(awr), 16'h0000);
        check(16'(ro), 16'h0001);
        @(negedge clock);
        resetn = 1'b0;
        repeat (2) @(negedge clock);
        resetn = 1'b1;
        check(16'(ro), 16'h0000);
        cmd1(dcm_pkg::DCM_CMD_READ, 15'h0003);
        check(16'(ard), 16'h0001);
        cmd1(dcm_pkg::DCM_CMD_WRITE, 15'h0000);
        check(16'(awr), 16'h0001);
        m.mrs(3'h1, 15'h0080);
        check(16'(wrlvl), 16'h0001);
        for (int j = 1; j >= 0; j--) begin
            m.frame(j[0], 1);
            repeat (6) @(negedge clock);
            check(16'(oe), 16'h0001);
            check(dq, {7'h00, j[0], 7'h00, j[0]});
        end
        m.mrs(3'h1, 15'h0000);
        check(16'(wrlvl), 16'h0000);
        give_verdict();
    end
endmodule
